/* File: shared/dpcd_defines.svh */
/*
 Constants for the DRAM power-down and command decode pair.
 Assumes: included by both ends, the checker and the bench by bare name.
*/
`ifndef DPCD_DEFINES_SVH
`define DPCD_DEFINES_SVH
`define DPCD_CKE_MIN_EDGES 3
`define DPCD_FREQ_WAIT_EDGES 2
`define DPCD_XSRD_EDGES 200
`define DPCD_BURST_EDGES 2
`define DPCD_REFI_EDGES 780
`define DPCD_PD_MAX_REFI 9
`define DPCD_XP_EDGES 2
`define DPCD_XARDS_EDGES 7
`define DPCD_DLL_LOCK_EDGES 200
`define DPCD_CLK_DIV 8
`define DPCD_SLOW_CLK_DIV 16
`endif

/* File: shared/dpcd_pkg.sv */
/*
 Types shared by both ends of the DRAM power-down pair.
 Assumes: compiled before the interface and modules.
*/
package dpcd_pkg;
   typedef enum logic [3:0] {
      CMD_DESELECT, CMD_NOP, CMD_ACTIVATE, CMD_PRECHARGE, CMD_READ, CMD_WRITE,
      CMD_REFRESH, CMD_MODE_SET, CMD_SELF_REF_ENTRY, CMD_PD_ENTRY, CMD_EXIT, CMD_NONE
   } dpcd_cmd_t;
   typedef enum logic [2:0] {
      DEV_IDLE, DEV_ACTIVE, DEV_PRE_PD, DEV_ACT_PD_FAST, DEV_ACT_PD_SLOW, DEV_SELF_REF
   } dpcd_dev_state_t;
endpackage

/* File: shared/dpcd_link_if.sv */
/*
 Pins between the memory controller end and the device end.
 Assumes: driven by the controller end on sys_clk, sampled by the device end on its own sys_clk.
*/
`timescale 1ns/1ps
interface dpcd_link_if;
   logic memClk;
   logic cke;
   logic chipSelN;
   logic rowStrobeN;
   logic colStrobeN;
   logic writeEnN;
   logic odt;
   logic [2:0] bankAddr;
   logic addr10;
   modport ctrl (output memClk, cke, chipSelN, rowStrobeN, colStrobeN, writeEnN, odt,
      bankAddr, addr10);
   modport dev (input memClk, cke, chipSelN, rowStrobeN, colStrobeN, writeEnN, odt,
      bankAddr, addr10);
endinterface

/* File: verilog/dpcd_device.sv */
/*
 Device end: samples the link clock, decodes commands at its rising edges,
 tracks banks and power-down, DLL and buffer enables.
 Assumes: link driven by dpcd_controller; sys_clk much faster than memClk.
*/
`timescale 1ns/1ps
`include "dpcd_defines.svh"
module dpcd_device #(
   parameter int BANKS = 8,
   parameter bit FAST_EXIT = 1'b1
) (
   input wire logic sys_clk,
   input wire logic reset,
   dpcd_link_if.dev link,
   output logic [3:0] lastCmd,
   output logic [2:0] lastBank,
   output logic lastAllBanks,
   output logic cmdStrobe,
   output logic [2:0] devState,
   output logic dllOn,
   output logic buffersOn,
   output logic [1:0] modeRegSel,
   output logic modeWrite
);
   typedef struct packed {
      logic [1:0] clkSync;
      logic clkPrev;
      logic [8:0] pinSync;
      logic [8:0] pinS2;
      logic ckePrev;
      logic [BANKS-1:0] openBanks;
      dpcd_pkg::dpcd_dev_state_t st;
      dpcd_pkg::dpcd_cmd_t cmd;
      logic [2:0] bank;
      logic allBanks;
      logic strobe;
      logic [1:0] mreg;
      logic mwrite;
   } dpcd_dev_reg_t;
   dpcd_dev_reg_t r;
   dpcd_dev_reg_t next_r;
   logic rise;
   logic cs, ras, cas, we, ckeNow, a10;
   logic [2:0] ba;
   dpcd_pkg::dpcd_cmd_t dec;
   always_comb begin
      next_r = r;
      next_r.clkSync = {r.clkSync[0], link.memClk};
      next_r.pinSync = {link.cke, link.chipSelN, link.rowStrobeN, link.colStrobeN,
         link.writeEnN, link.addr10, link.bankAddr};
      next_r.pinS2 = r.pinSync;
      next_r.clkPrev = r.clkSync[1];
      next_r.strobe = 1'b0;
      next_r.mwrite = 1'b0;
      rise = r.clkSync[1] & ~r.clkPrev;
      {ckeNow, cs, ras, cas, we, a10, ba} = r.pinS2;
      dec = dpcd_pkg::CMD_NONE;
      if (!r.ckePrev) begin
         if (ckeNow && (cs || (ras && cas && we))) begin
            dec = dpcd_pkg::CMD_EXIT;
         end
      end else if (cs) begin
         dec = ckeNow ? dpcd_pkg::CMD_DESELECT : dpcd_pkg::CMD_PD_ENTRY;
      end else begin
         unique case ({ras, cas, we})
            3'h7: dec = ckeNow ? dpcd_pkg::CMD_NOP : dpcd_pkg::CMD_PD_ENTRY;
            3'h3: dec = dpcd_pkg::CMD_ACTIVATE;
            3'h2: dec = dpcd_pkg::CMD_PRECHARGE;
            3'h5: dec = dpcd_pkg::CMD_READ;
            3'h4: dec = dpcd_pkg::CMD_WRITE;
            3'h1: dec = ckeNow ? dpcd_pkg::CMD_REFRESH : dpcd_pkg::CMD_SELF_REF_ENTRY;
            3'h0: dec = dpcd_pkg::CMD_MODE_SET;
            default: dec = dpcd_pkg::CMD_NONE;
         endcase
         if (!ckeNow && dec != dpcd_pkg::CMD_SELF_REF_ENTRY
               && dec != dpcd_pkg::CMD_PD_ENTRY) begin
            dec = dpcd_pkg::CMD_NONE;
         end
      end
      // self refresh exit is asynchronous to the command clock
      if (r.st == dpcd_pkg::DEV_SELF_REF && ckeNow && (cs || (ras && cas && we))) begin
         next_r.st = dpcd_pkg::DEV_IDLE;
      end
      if (rise) begin
         next_r.ckePrev = ckeNow;
         if (dec != dpcd_pkg::CMD_NONE) begin
            next_r.cmd = dec;
            next_r.bank = ba;
            next_r.allBanks = a10;
            next_r.strobe = 1'b1;
         end
         unique case (dec)
            dpcd_pkg::CMD_ACTIVATE: next_r.openBanks[ba] = 1'b1;
            dpcd_pkg::CMD_PRECHARGE: begin
               if (a10) begin
                  next_r.openBanks = '0;
               end else begin
                  next_r.openBanks[ba] = 1'b0;
               end
            end
            dpcd_pkg::CMD_READ, dpcd_pkg::CMD_WRITE: begin
               if (a10) begin
                  next_r.openBanks[ba] = 1'b0;
               end
            end
            dpcd_pkg::CMD_MODE_SET: begin
               next_r.mreg = ba[1:0];
               next_r.mwrite = 1'b1;
            end
            dpcd_pkg::CMD_SELF_REF_ENTRY: next_r.st = dpcd_pkg::DEV_SELF_REF;
            dpcd_pkg::CMD_PD_ENTRY: begin
               if (r.openBanks == '0) begin
                  next_r.st = dpcd_pkg::DEV_PRE_PD;
               end else begin
                  next_r.st = FAST_EXIT ? dpcd_pkg::DEV_ACT_PD_FAST
                     : dpcd_pkg::DEV_ACT_PD_SLOW;
               end
            end
            dpcd_pkg::CMD_EXIT: begin
               if (r.st != dpcd_pkg::DEV_SELF_REF) begin
                  next_r.st = (r.openBanks == '0) ? dpcd_pkg::DEV_IDLE
                     : dpcd_pkg::DEV_ACTIVE;
               end
            end
            default: begin
            end
         endcase
         if (next_r.st == dpcd_pkg::DEV_IDLE && next_r.openBanks != '0) begin
            next_r.st = dpcd_pkg::DEV_ACTIVE;
         end else if (next_r.st == dpcd_pkg::DEV_ACTIVE && next_r.openBanks == '0) begin
            next_r.st = dpcd_pkg::DEV_IDLE;
         end
      end
   end
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         r <= '0;
         r.st <= dpcd_pkg::DEV_IDLE;
         r.cmd <= dpcd_pkg::CMD_NONE;
         // cke idles high, so no false exit at the first edge
         r.ckePrev <= 1'b1;
      end else begin
         r <= next_r;
      end
   end
   assign lastCmd = r.cmd;
   assign lastBank = r.bank;
   assign lastAllBanks = r.allBanks;
   assign cmdStrobe = r.strobe;
   assign devState = r.st;
   assign dllOn = !(r.st == dpcd_pkg::DEV_PRE_PD || r.st == dpcd_pkg::DEV_ACT_PD_SLOW
      || r.st == dpcd_pkg::DEV_SELF_REF);
   assign buffersOn = (r.st == dpcd_pkg::DEV_IDLE || r.st == dpcd_pkg::DEV_ACTIVE);
   assign modeRegSel = r.mreg;
   assign modeWrite = r.mwrite;
endmodule

/* File: verilog/dpcd_controller.sv */
/*
 Controller end: makes the link clock by division, drives commands, CKE
 and ODT with the power-down and clock change timing.
 Assumes: user pulses one request at a time while ready is high.
*/
`timescale 1ns/1ps
`include "dpcd_defines.svh"
module dpcd_controller #(
   parameter int PD_LIMIT = `DPCD_PD_MAX_REFI * `DPCD_REFI_EDGES
) (
   input wire logic sys_clk,
   input wire logic reset,
   dpcd_link_if.ctrl link,
   input wire logic reqValid,
   input wire logic [3:0] reqCmd,
   input wire logic [2:0] reqBank,
   input wire logic reqAll,
   input wire logic reqSlowClk,
   input wire logic reqOdt,
   output logic ready,
   output logic [1:0] pdPhase
);
   typedef enum logic [2:0] {C_RUN, C_PD, C_SR, C_EXIT, C_LOCK} dpcd_cst_t;
   typedef struct packed {
      dpcd_cst_t st;
      logic [4:0] div;
      logic clk;
      logic slow;
      logic slowPend;
      logic cke;
      logic [3:0] cmdBits;
      logic [2:0] bank;
      logic a10;
      logic odt;
      logic [15:0] cnt;
      logic [15:0] pdCnt;
      logic modeSetDue;
      logic [7:0] openBanks;
   } dpcd_ctl_reg_t;
   dpcd_ctl_reg_t r;
   dpcd_ctl_reg_t next_r;
   logic edgeFall;
   logic [4:0] divMax;
   logic [3:0] enc;
   always_comb begin
      divMax = r.slow ? 5'(`DPCD_SLOW_CLK_DIV / 2 - 1) : 5'(`DPCD_CLK_DIV / 2 - 1);
      next_r = r;
      edgeFall = 1'b0;
      if (r.div == divMax) begin
         next_r.div = '0;
         next_r.clk = ~r.clk;
         edgeFall = r.clk;
      end else begin
         next_r.div = r.div + 5'h01;
      end
      unique case (dpcd_pkg::dpcd_cmd_t'(reqCmd))
         dpcd_pkg::CMD_ACTIVATE: enc = 4'h3;
         dpcd_pkg::CMD_PRECHARGE: enc = 4'h2;
         dpcd_pkg::CMD_READ: enc = 4'h5;
         dpcd_pkg::CMD_WRITE: enc = 4'h4;
         dpcd_pkg::CMD_REFRESH, dpcd_pkg::CMD_SELF_REF_ENTRY: enc = 4'h1;
         dpcd_pkg::CMD_MODE_SET: enc = 4'h0;
         default: enc = 4'h7;
      endcase
      // no ready while a queued mode set or clock change would swallow the request
      ready = edgeFall && r.cnt == '0 && ((r.st == C_RUN && !r.modeSetDue)
         || (r.st == C_PD && !r.slowPend) || r.st == C_SR);
      pdPhase = (r.st == C_RUN) ? 2'h0 : (r.st == C_PD) ? 2'h1 : (r.st == C_SR) ? 2'h2 : 2'h3;
      if (edgeFall) begin
         // new values are set up half a period before the device's rising edge
         next_r.cmdBits = 4'h7;
         if (r.cnt != '0) begin
            next_r.cnt = r.cnt - 16'h0001;
         end
         if (r.st == C_PD) begin
            next_r.pdCnt = r.pdCnt + 16'h0001;
         end
         unique case (r.st)
            C_RUN: begin
               next_r.odt = reqOdt & ~r.modeSetDue;
               if (r.modeSetDue && r.cnt == '0) begin
                  next_r.cmdBits = 4'h0;
                  next_r.bank = '0;
                  next_r.modeSetDue = 1'b0;
                  next_r.cnt = 16'(`DPCD_DLL_LOCK_EDGES);
                  next_r.st = C_LOCK;
               end else if (reqValid && r.cnt == '0) begin
                  next_r.cmdBits = enc;
                  next_r.bank = reqBank;
                  next_r.a10 = reqAll;
                  // open rows tracked so a clock change is refused in active power-down
                  if (reqCmd == dpcd_pkg::CMD_ACTIVATE) begin
                     next_r.openBanks[reqBank] = 1'b1;
                  end else if (reqCmd == dpcd_pkg::CMD_PRECHARGE && reqAll) begin
                     next_r.openBanks = '0;
                  end else if (reqCmd == dpcd_pkg::CMD_PRECHARGE
                        || (reqAll && reqCmd == dpcd_pkg::CMD_READ)
                        || (reqAll && reqCmd == dpcd_pkg::CMD_WRITE)) begin
                     next_r.openBanks[reqBank] = 1'b0;
                  end
                  if (reqCmd == dpcd_pkg::CMD_PD_ENTRY) begin
                     next_r.cke = 1'b0;
                     next_r.odt = 1'b0;
                     next_r.slowPend = reqSlowClk && r.openBanks == '0;
                     next_r.pdCnt = '0;
                     next_r.cnt = 16'(`DPCD_CKE_MIN_EDGES);
                     next_r.st = C_PD;
                  end else if (reqCmd == dpcd_pkg::CMD_SELF_REF_ENTRY) begin
                     next_r.cke = 1'b0;
                     next_r.odt = 1'b0;
                     next_r.cnt = 16'(`DPCD_CKE_MIN_EDGES);
                     next_r.st = C_SR;
                  end else if (reqCmd == dpcd_pkg::CMD_READ
                        || reqCmd == dpcd_pkg::CMD_WRITE) begin
                     next_r.cnt = 16'(`DPCD_BURST_EDGES);
                  end
               end
            end
            C_PD, C_SR: begin
               next_r.odt = 1'b0;
               if (r.st == C_PD && r.slowPend
                     && r.pdCnt >= 16'(`DPCD_FREQ_WAIT_EDGES)) begin
                  next_r.slow = ~r.slow;
                  next_r.slowPend = 1'b0;
                  next_r.modeSetDue = 1'b1;
               end
               if (r.cnt == '0 && !r.slowPend && (reqValid
                     || (r.st == C_PD && r.pdCnt >= 16'(PD_LIMIT)))) begin
                  next_r.cke = 1'b1;
                  // exit carries a deselect
                  next_r.cmdBits = 4'hF;
                  next_r.cnt = (r.st == C_SR) ? 16'(`DPCD_XSRD_EDGES)
                     : 16'(`DPCD_XARDS_EDGES > `DPCD_CKE_MIN_EDGES ? `DPCD_XARDS_EDGES
                     : `DPCD_CKE_MIN_EDGES);
                  next_r.st = C_EXIT;
               end
            end
            C_EXIT: begin
               if (r.cnt == '0) begin
                  next_r.st = C_RUN;
               end
            end
            C_LOCK: begin
               next_r.odt = 1'b0;
               if (r.cnt == '0) begin
                  next_r.st = C_RUN;
               end
            end
            default: next_r.st = C_RUN;
         endcase
      end
   end
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         r <= '0;
         r.st <= C_RUN;
         r.cke <= 1'b1;
         r.cmdBits <= 4'h7;
      end else begin
         r <= next_r;
      end
   end
   assign link.memClk = r.clk;
   assign link.cke = r.cke;
   assign link.chipSelN = r.cmdBits[3];
   assign {link.rowStrobeN, link.colStrobeN, link.writeEnN} = r.cmdBits[2:0];
   assign link.odt = r.odt;
   assign link.bankAddr = r.bank;
   assign link.addr10 = r.a10;
endmodule

/* File: sim/dpcd_link_properties.sv */
/*
 Checker of the link between controller end and device end.
 Assumes: instantiated in the bench beside the link interface.
*/
`timescale 1ns/1ps
`include "dpcd_defines.svh"
module dpcd_link_properties #(
   parameter int PD_LIMIT = `DPCD_PD_MAX_REFI * `DPCD_REFI_EDGES
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic memClk,
   input wire logic cke,
   input wire logic chipSelN,
   input wire logic rowStrobeN,
   input wire logic colStrobeN,
   input wire logic writeEnN,
   input wire logic odt,
   input wire logic [2:0] bankAddr,
   input wire logic addr10
);
   logic memQ;
   logic ckeQ;
   logic srFlag;
   logic [1:0] holdCnt;
   logic [2:0] xpCnt;
   logic [1:0] burstCnt;
   logic [7:0] srCnt;
   logic [15:0] pdCnt;
   wire memRise = memClk & ~memQ;
   wire nopCmd = chipSelN | (rowStrobeN & colStrobeN & writeEnN);
   wire refCmd = ~chipSelN & ~rowStrobeN & ~colStrobeN & writeEnN;
   wire rwCmd = ~chipSelN & rowStrobeN & ~colStrobeN;
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         memQ <= 1'b0;
         ckeQ <= 1'b1;
         srFlag <= 1'b0;
         holdCnt <= 2'h3;
         xpCnt <= 3'h7;
         burstCnt <= 2'h3;
         srCnt <= 8'hFF;
         pdCnt <= 16'h0;
      end else begin
         memQ <= memClk;
         ckeQ <= cke;
         if (cke != ckeQ) holdCnt <= 2'h0;
         else if (memRise && holdCnt != 2'h3) holdCnt <= holdCnt + 2'h1;
         if (cke && !ckeQ) xpCnt <= 3'h0;
         else if (memRise && xpCnt != 3'h7) xpCnt <= xpCnt + 3'h1;
         if (cke && !ckeQ) srCnt <= 8'h0;
         else if (memRise && srCnt != 8'hFF) srCnt <= srCnt + 8'h1;
         if (!cke && ckeQ) srFlag <= refCmd;
         if (memRise) burstCnt <= rwCmd ? 2'h0 : (burstCnt == 2'h3 ? 2'h3 : burstCnt + 2'h1);
         if (cke) pdCnt <= 16'h0;
         else if (memRise && !srFlag) pdCnt <= pdCnt + 16'h1;
      end
   end
   property p_cke_hold;
      @(posedge sys_clk) disable iff (reset) (cke != ckeQ) |-> holdCnt == 2'h3;
   endproperty
   a_cke_hold: assert property (p_cke_hold) else $error("cke changed too soon");
   property p_entry_cmd;
      @(posedge sys_clk) disable iff (reset) (ckeQ && !cke) |-> (nopCmd || refCmd);
   endproperty
   a_entry_cmd: assert property (p_entry_cmd) else $error("bad entry command");
   property p_exit_cmd;
      @(posedge sys_clk) disable iff (reset) (!ckeQ && cke) |-> nopCmd;
   endproperty
   a_exit_cmd: assert property (p_exit_cmd) else $error("bad exit command");
   property p_exit_wait;
      @(posedge sys_clk) disable iff (reset) (memRise && xpCnt < 3'h2) |-> nopCmd;
   endproperty
   a_exit_wait: assert property (p_exit_wait) else $error("command inside exit latency");
   property p_sr_read;
      @(posedge sys_clk) disable iff (reset)
         (memRise && srFlag && srCnt < 8'hC8) |-> !(rwCmd && writeEnN);
   endproperty
   a_sr_read: assert property (p_sr_read) else $error("read too soon after self refresh");
   property p_burst;
      @(posedge sys_clk) disable iff (reset) (memRise && rwCmd) |-> burstCnt != 2'h0;
   endproperty
   a_burst: assert property (p_burst) else $error("burst cut short");
   property p_odt_pd;
      @(posedge sys_clk) disable iff (reset) (!cke && !ckeQ) |-> $stable(odt);
   endproperty
   a_odt_pd: assert property (p_odt_pd) else $error("odt moved in power-down");
   property p_pd_len;
      @(posedge sys_clk) disable iff (reset) pdCnt <= PD_LIMIT + 1;
   endproperty
   a_pd_len: assert property (p_pd_len) else $error("power-down too long");
endmodule

/* File: sim/dram_powerdown_cmd_decode_tb.sv */
/*
 Bench: controller end and device end joined by the link, user sides driven here.
 Assumes: design, interface and checker compiled before it.
*/
`timescale 1ns/1ps
`include "dpcd_defines.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
   $display("BAD %s exp %0h got %0h", n, e, g); error_cnt++; end end
module dram_powerdown_cmd_decode_tb;
   localparam int PD_LIMIT = 50;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic reqValid = 1'b0;
   logic [3:0] reqCmd = 4'h0;
   logic [2:0] reqBank = 3'h0;
   logic reqAll = 1'b0;
   logic reqSlowClk = 1'b0;
   logic reqOdt = 1'b0;
   logic ready, lastAllBanks, cmdStrobe, dllOn, buffersOn, modeWrite;
   logic [1:0] pdPhase, modeRegSel;
   logic [3:0] lastCmd;
   logic [2:0] lastBank, devState;
   logic [2:0] slowState;
   logic slowDllOn;
   int error_cnt = 0;
   int checked = 0;
   int cycles = 0;
   dpcd_link_if link ();
   dpcd_controller #(.PD_LIMIT(PD_LIMIT)) u_dpcd_controller (.sys_clk(sys_clk), .reset(reset),
      .link(link), .reqValid(reqValid), .reqCmd(reqCmd), .reqBank(reqBank), .reqAll(reqAll),
      .reqSlowClk(reqSlowClk), .reqOdt(reqOdt), .ready(ready), .pdPhase(pdPhase));
   dpcd_device u_dpcd_device (.sys_clk(sys_clk), .reset(reset), .link(link), .lastCmd(lastCmd),
      .lastBank(lastBank), .lastAllBanks(lastAllBanks), .cmdStrobe(cmdStrobe),
      .devState(devState), .dllOn(dllOn), .buffersOn(buffersOn), .modeRegSel(modeRegSel),
      .modeWrite(modeWrite));
   // second device on the same link, built for slow exit
   dpcd_device #(.FAST_EXIT(1'b0)) u_dpcd_device_slow (.sys_clk(sys_clk), .reset(reset),
      .link(link), .lastCmd(), .lastBank(), .lastAllBanks(), .cmdStrobe(),
      .devState(slowState), .dllOn(slowDllOn), .buffersOn(), .modeRegSel(), .modeWrite());
   dpcd_link_properties #(.PD_LIMIT(PD_LIMIT)) u_dpcd_link_properties (.sys_clk(sys_clk),
      .reset(reset), .memClk(link.memClk), .cke(link.cke), .chipSelN(link.chipSelN),
      .rowStrobeN(link.rowStrobeN), .colStrobeN(link.colStrobeN), .writeEnN(link.writeEnN),
      .odt(link.odt), .bankAddr(link.bankAddr), .addr10(link.addr10));
   task automatic print_verdict();
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic req(input dpcd_pkg::dpcd_cmd_t c, input logic [2:0] b, input logic a,
      input logic s);
      @(negedge sys_clk);
      reqCmd = c;
      reqBank = b;
      reqAll = a;
      reqSlowClk = s;
      reqValid = 1'b1;
      while (ready !== 1'b1) @(negedge sys_clk);
      @(negedge sys_clk);
      reqValid = 1'b0;
      reqSlowClk = 1'b0;
   endtask
   task automatic expect_cmd(input dpcd_pkg::dpcd_cmd_t c);
      for (int n = 0; n < 400 && lastCmd !== c; n++) @(negedge sys_clk);
      `CHK("lastCmd", c, lastCmd)
   endtask
   task automatic expect_state(input dpcd_pkg::dpcd_dev_state_t s);
      for (int n = 0; n < 4000 && devState !== s; n++) @(negedge sys_clk);
      `CHK("devState", s, devState)
   endtask
   task automatic t_commands();
      req(dpcd_pkg::CMD_ACTIVATE, 3'h5, 1'b0, 1'b0);
      expect_cmd(dpcd_pkg::CMD_ACTIVATE);
      `CHK("lastBank", 3'h5, lastBank)
      expect_state(dpcd_pkg::DEV_ACTIVE);
      req(dpcd_pkg::CMD_READ, 3'h5, 1'b1, 1'b0);
      expect_cmd(dpcd_pkg::CMD_READ);
      `CHK("lastAllBanks", 1'b1, lastAllBanks)
      expect_state(dpcd_pkg::DEV_IDLE);
      req(dpcd_pkg::CMD_ACTIVATE, 3'h2, 1'b0, 1'b0);
      req(dpcd_pkg::CMD_WRITE, 3'h2, 1'b0, 1'b0);
      expect_cmd(dpcd_pkg::CMD_WRITE);
      `CHK("lastBank", 3'h2, lastBank)
      req(dpcd_pkg::CMD_PRECHARGE, 3'h0, 1'b1, 1'b0);
      expect_cmd(dpcd_pkg::CMD_PRECHARGE);
      expect_state(dpcd_pkg::DEV_IDLE);
      req(dpcd_pkg::CMD_MODE_SET, 3'h2, 1'b0, 1'b0);
      expect_cmd(dpcd_pkg::CMD_MODE_SET);
      `CHK("modeRegSel", 2'h2, modeRegSel)
      `CHK("modeWrite", 1'b1, modeWrite)
      `CHK("cmdStrobe", 1'b1, cmdStrobe)
      @(negedge sys_clk);
      `CHK("modeWrite", 1'b0, modeWrite)
   endtask
   task automatic t_precharge_pd();
      req(dpcd_pkg::CMD_PD_ENTRY, 3'h0, 1'b0, 1'b0);
      expect_state(dpcd_pkg::DEV_PRE_PD);
      `CHK("dllOn", 1'b0, dllOn)
      `CHK("buffersOn", 1'b0, buffersOn)
      `CHK("pdPhase", 2'h1, pdPhase)
      `CHK("odt", 1'b0, link.odt)
      req(dpcd_pkg::CMD_EXIT, 3'h0, 1'b0, 1'b0);
      expect_state(dpcd_pkg::DEV_IDLE);
      `CHK("buffersOn", 1'b1, buffersOn)
      `CHK("pdPhase", 2'h3, pdPhase)
   endtask
   task automatic t_active_pd();
      req(dpcd_pkg::CMD_ACTIVATE, 3'h1, 1'b0, 1'b0);
      req(dpcd_pkg::CMD_PD_ENTRY, 3'h0, 1'b0, 1'b0);
      expect_state(dpcd_pkg::DEV_ACT_PD_FAST);
      `CHK("slowState", dpcd_pkg::DEV_ACT_PD_SLOW, slowState)
      `CHK("slowDllOn", 1'b0, slowDllOn)
      `CHK("dllOn", 1'b1, dllOn)
      `CHK("buffersOn", 1'b0, buffersOn)
      req(dpcd_pkg::CMD_EXIT, 3'h0, 1'b0, 1'b0);
      expect_state(dpcd_pkg::DEV_ACTIVE);
      req(dpcd_pkg::CMD_PRECHARGE, 3'h0, 1'b1, 1'b0);
      expect_state(dpcd_pkg::DEV_IDLE);
   endtask
   task automatic t_self_ref();
      req(dpcd_pkg::CMD_SELF_REF_ENTRY, 3'h0, 1'b0, 1'b0);
      expect_state(dpcd_pkg::DEV_SELF_REF);
      `CHK("pdPhase", 2'h2, pdPhase)
      req(dpcd_pkg::CMD_EXIT, 3'h0, 1'b0, 1'b0);
      expect_state(dpcd_pkg::DEV_IDLE);
      req(dpcd_pkg::CMD_ACTIVATE, 3'h3, 1'b0, 1'b0);
      req(dpcd_pkg::CMD_READ, 3'h3, 1'b0, 1'b0);
      expect_cmd(dpcd_pkg::CMD_READ);
      req(dpcd_pkg::CMD_PRECHARGE, 3'h0, 1'b1, 1'b0);
      expect_state(dpcd_pkg::DEV_IDLE);
   endtask
   task automatic t_pd_limit();
      req(dpcd_pkg::CMD_PD_ENTRY, 3'h0, 1'b0, 1'b0);
      expect_state(dpcd_pkg::DEV_PRE_PD);
      expect_state(dpcd_pkg::DEV_IDLE);
   endtask
   task automatic t_freq();
      int t0;
      req(dpcd_pkg::CMD_PD_ENTRY, 3'h0, 1'b0, 1'b1);
      expect_state(dpcd_pkg::DEV_PRE_PD);
      `CHK("dllOn", 1'b0, dllOn)
      req(dpcd_pkg::CMD_EXIT, 3'h0, 1'b0, 1'b0);
      expect_state(dpcd_pkg::DEV_IDLE);
      expect_cmd(dpcd_pkg::CMD_MODE_SET);
      `CHK("modeRegSel", 2'h0, modeRegSel)
      `CHK("odt", 1'b0, link.odt)
      // link clock now runs at the slow rate
      @(posedge link.memClk);
      t0 = cycles;
      @(posedge link.memClk);
      `CHK("memClkPeriod", `DPCD_SLOW_CLK_DIV, cycles - t0)
   endtask
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 40000) begin
         error_cnt++;
         print_verdict();
      end
   end
   initial begin
      repeat (5) @(negedge sys_clk);
      reset = 1'b0;
      reqOdt = 1'b1;
      t_commands();
      t_precharge_pd();
      t_active_pd();
      t_self_ref();
      t_pd_limit();
      t_freq();
      print_verdict();
   end
endmodule
